// >>> hdl/sbtc_pkg.sv
package sbtc_pkg;

   // ************************************************************
   // Register map (byte addresses, one aligned word each)
   // ************************************************************
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_CNT_LO = 8'h04;
   localparam logic [7:0] OFF_CNT_HI = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   localparam logic [7:0] OFF_CMP_LO = 8'h10;
   localparam logic [7:0] OFF_CMP_HI = 8'h14;
   localparam logic [7:0] OFF_CMP_MODE = 8'h18;

   // One-hot decode positions
   localparam int REG_NUM = 7;
   localparam int IDX_CTRL = 0;
   localparam int IDX_CNT_LO = 1;
   localparam int IDX_CNT_HI = 2;
   localparam int IDX_STATUS = 3;
   localparam int IDX_CMP_LO = 4;
   localparam int IDX_CMP_HI = 5;
   localparam int IDX_CMP_MODE = 6;

   // ************************************************************
   // Fields, reset values and constants
   // ************************************************************
   localparam int STAT_OVF_BIT = 0;
   localparam int STAT_SLEEP_BIT = 1;
   localparam logic [5:0] CTRL_RESET = 6'h00;
   localparam logic [3:0] CMP_MODE_RESET = 4'h0;
   localparam logic [3:0] CMP_MODE_TRIG = 4'hb;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [15:0] CMP_RESET = 16'h0000;
   localparam int PRESC_W = 3;
   localparam logic [PRESC_W-1:0] PRESC_ZERO = 3'h0;
   localparam logic [PRESC_W-1:0] PRESC_ONE = 3'h1;
   localparam logic [1:0] PRESC_DIV1 = 2'h0;
   localparam int NUM_PINS = 2;
   localparam int PIN_EXT = 0;
   localparam int PIN_OSC = 1;

   typedef struct packed {
      logic [1:0] prescale;
      logic auxOsc;
      logic syncDis;
      logic clkSel;
      logic run;
   } sbtc_ctrl_s;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } sbtc_wb_req_s;

   // Instruction cycle phases, one clock each
   typedef enum logic [3:0] {
      PH_Q1 = 4'b0001,
      PH_Q2 = 4'b0010,
      PH_Q3 = 4'b0100,
      PH_Q4 = 4'b1000
   } sbtc_phase_e;

endpackage

// >>> hdl/sbtc_sync.sv
`timescale 1ns/1ps
module sbtc_sync (
   input wire logic clk, // Clock
   input wire logic rst, // Synchronous reset
   input wire logic din, // Pin level, asynchronous
   output logic level, // Filtered level
   output logic rise // One-cycle pulse on rising level
);
   logic meta_q;
   logic s2_q;
   logic s3_q;
   logic level_q;
   logic rise_q;

   // Level moves only once the second and third stages agree
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level_q <= 1'b0;
         rise_q <= 1'b0;
      end else begin
         meta_q <= din;
         s2_q <= meta_q;
         s3_q <= s2_q;
         rise_q <= 1'b0;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
            rise_q <= s3_q & ~level_q;
         end
      end
   end

   assign level = level_q;
   assign rise = rise_q;
endmodule

// >>> hdl/sbtc_prescaler.sv
`timescale 1ns/1ps
module sbtc_prescaler
   import sbtc_pkg::*;
(
   input wire logic clk, // Clock
   input wire logic rst, // Synchronous reset
   input wire logic clear, // Clear the divider
   input wire logic edgeIn, // Rising edge of the selected source
   input wire logic levelIn, // Level of the selected source
   input wire logic [1:0] sel, // Divide 1, 2, 4, 8
   output logic out // Divided, symmetrical output
);
   logic [PRESC_W-1:0] cnt_q;

   // Keeps counting whatever the sleep state is
   always_ff @(posedge clk) begin
      if (rst || clear) begin
         cnt_q <= PRESC_ZERO;
      end else if (edgeIn) begin
         cnt_q <= cnt_q + PRESC_ONE;
      end
   end

   // Divide by one passes the source level itself
   always_comb begin
      if (sel == PRESC_DIV1) begin
         out = levelIn;
      end else begin
         out = cnt_q[sel - 2'h1];
      end
   end
endmodule

// >>> hdl/sbtc_top.sv
// Contract
// - Clock select clear: count once per four clocks, sync bit ignored.
// - Clock select set: count edges of osc input or external clock pin.
// - Sync enabled: synchronise after prescaler; prescaler is ripple style.
// - Synchronised counter in sleep holds; prescaler keeps counting.
// - Prescaler output sampled on Q2 and Q4; source high/low 2 Tosc.
// - Synchronised count updates after the synchroniser delay.
// - Async mode counts in sleep; overflow can wake the processor.
// - Async mode is no time base for compare.
// - Byte reads in async mode return a coherent value.
// - Aux oscillator enable starts inverter, runs through sleep.
// - Compare mode 1011 trigger clears count, flag untouched.
// - Trigger clear works in timer and synchronised modes only.
// - Count write in trigger cycle wins over the trigger.
// - Compare value acts as period under trigger clear.
// - No reset clears the count; only the trigger does.
// - Power-on reset clears control; other resets leave it.
// - Count runs 0000h to FFFFh, wraps, sets overflow flag.
// - Run enable starts and stops counting.
// - Any count byte write clears the prescaler.
//
// Added by the designer: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module sbtc_top (
   input wire logic clk, // 125 MHz clock
   input wire logic rst, // Power-on/brown-out reset
   input wire logic rstOther, // Any other device reset
   input wire sbtc_pkg::sbtc_wb_req_s wbReq, // Wishbone request
   output logic [31:0] wbDatO, // Wishbone read data
   output logic wbAck, // Wishbone acknowledge
   input wire logic sleepMode, // Processor asleep
   input wire logic extClkPin, // External clock pin
   input wire logic oscInPin, // Crystal oscillator input pin
   output logic oscOutPin, // Crystal amplifier output
   output logic oscOutOe, // Amplifier output enable
   output logic overflowFlag, // Sticky overflow flag
   output logic wakeUp // Wake pulse on overflow in sleep
);
   import sbtc_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   sbtc_ctrl_s ctrl_q;
   sbtc_phase_e phase_q;
   logic [15:0] count_q;
   logic [15:0] count_d;
   logic [15:0] cmpVal_q;
   logic [3:0] cmpMode_q;
   logic ovf_q;
   logic wake_q;
   logic ack_q;
   logic [31:0] rdat_q;
   logic oscOut_q;
   logic oscOe_q;
   logic prescPrev_q;
   logic smp_q;
   logic syncInc_q;
   logic [1:0] cntKnown_q;

   logic [NUM_PINS-1:0] pinRaw;
   logic [NUM_PINS-1:0] pinLvl;
   logic [NUM_PINS-1:0] pinRise;
   logic srcLvl;
   logic srcRise;
   logic prescOut;
   logic sampleNow;
   logic asyncMode;
   logic inc;
   logic trig;
   logic ovfSet;
   logic busHit;
   logic wrStb;
   logic [REG_NUM-1:0] wrSel;
   logic [REG_NUM-1:0] rdSel;
   logic cntLoWr;
   logic cntHiWr;
   logic cntWr;

   function automatic logic [REG_NUM-1:0] regDecode(input logic [7:0] adr);
      logic [REG_NUM-1:0] hot;
      hot = '0;
      if (adr[1:0] == 2'h0) begin
         hot[IDX_CTRL] = (adr == OFF_CTRL);
         hot[IDX_CNT_LO] = (adr == OFF_CNT_LO);
         hot[IDX_CNT_HI] = (adr == OFF_CNT_HI);
         hot[IDX_STATUS] = (adr == OFF_STATUS);
         hot[IDX_CMP_LO] = (adr == OFF_CMP_LO);
         hot[IDX_CMP_HI] = (adr == OFF_CMP_HI);
         hot[IDX_CMP_MODE] = (adr == OFF_CMP_MODE);
      end
      return hot;
   endfunction

   // ************************************************************
   // Wishbone slave
   // ************************************************************
   assign busHit = wbReq.cyc & wbReq.stb;
   // Writes land on the edge where the master samples ack
   assign wrStb = busHit & wbReq.we & ack_q & wbReq.sel[0];
   assign wrSel = wrStb ? regDecode(wbReq.adr) : '0;
   assign rdSel = regDecode(wbReq.adr);
   assign cntLoWr = wrSel[IDX_CNT_LO];
   assign cntHiWr = wrSel[IDX_CNT_HI];
   assign cntWr = cntLoWr | cntHiWr;

   always_ff @(posedge clk) begin
      if (rst || rstOther) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= busHit & ~ack_q;
      end
   end

   // Count is read straight from the live register, so a byte is coherent
   always_ff @(posedge clk) begin
      if (rst || rstOther) begin
         rdat_q <= 32'h0000_0000;
      end else if (busHit && !ack_q) begin
         rdat_q <= 32'h0000_0000;
         case (1'b1)
            rdSel[IDX_CTRL]: rdat_q[5:0] <= ctrl_q;
            rdSel[IDX_CNT_LO]: rdat_q[7:0] <= count_q[7:0];
            rdSel[IDX_CNT_HI]: rdat_q[7:0] <= count_q[15:8];
            rdSel[IDX_STATUS]: begin
               rdat_q[STAT_OVF_BIT] <= ovf_q;
               rdat_q[STAT_SLEEP_BIT] <= sleepMode;
            end
            rdSel[IDX_CMP_LO]: rdat_q[7:0] <= cmpVal_q[7:0];
            rdSel[IDX_CMP_HI]: rdat_q[7:0] <= cmpVal_q[15:8];
            rdSel[IDX_CMP_MODE]: rdat_q[3:0] <= cmpMode_q;
            default: rdat_q <= 32'h0000_0000;
         endcase
      end
   end

   // ************************************************************
   // Control and compare registers
   // ************************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q <= CTRL_RESET;
      end else if (wrSel[IDX_CTRL]) begin
         ctrl_q <= wbReq.dat[5:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst || rstOther) begin
         cmpVal_q <= CMP_RESET;
         cmpMode_q <= CMP_MODE_RESET;
      end else begin
         if (wrSel[IDX_CMP_LO]) begin
            cmpVal_q[7:0] <= wbReq.dat[7:0];
         end
         if (wrSel[IDX_CMP_HI]) begin
            cmpVal_q[15:8] <= wbReq.dat[7:0];
         end
         if (wrSel[IDX_CMP_MODE]) begin
            cmpMode_q <= wbReq.dat[3:0];
         end
      end
   end

   // ************************************************************
   // Instruction phase and count source
   // ************************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         phase_q <= PH_Q1;
      end else begin
         case (phase_q)
            PH_Q1: phase_q <= PH_Q2;
            PH_Q2: phase_q <= PH_Q3;
            PH_Q3: phase_q <= PH_Q4;
            PH_Q4: phase_q <= PH_Q1;
            default: phase_q <= PH_Q1;
         endcase
      end
   end

   assign pinRaw[PIN_EXT] = extClkPin;
   assign pinRaw[PIN_OSC] = oscInPin;

   for (genvar i = 0; i < NUM_PINS; i++) begin : gSync
      sbtc_sync uSync (
         .clk(clk),
         .rst(rst),
         .din(pinRaw[i]),
         .level(pinLvl[i]),
         .rise(pinRise[i])
      );
   end

   assign srcLvl = ctrl_q.auxOsc ? pinLvl[PIN_OSC] : pinLvl[PIN_EXT];
   assign srcRise = ctrl_q.auxOsc ? pinRise[PIN_OSC] : pinRise[PIN_EXT];

   // Divider sits ahead of the phase sampling
   sbtc_prescaler uPresc (
      .clk(clk),
      .rst(rst),
      .clear(cntWr),
      .edgeIn(ctrl_q.clkSel & srcRise),
      .levelIn(srcLvl),
      .sel(ctrl_q.prescale),
      .out(prescOut)
   );

   // Sampling stops in sleep, so the divider runs on alone there
   assign sampleNow = ~sleepMode & ((phase_q == PH_Q2) | (phase_q == PH_Q4));

   always_ff @(posedge clk) begin
      if (rst) begin
         smp_q <= 1'b0;
         syncInc_q <= 1'b0;
         prescPrev_q <= 1'b0;
      end else begin
         prescPrev_q <= prescOut;
         syncInc_q <= sampleNow & prescOut & ~smp_q;
         if (sampleNow) begin
            smp_q <= prescOut;
         end
      end
   end

   assign asyncMode = ctrl_q.clkSel & ctrl_q.syncDis;

   always_comb begin
      inc = 1'b0;
      if (!ctrl_q.clkSel) begin
         inc = ctrl_q.run & ~sleepMode & (phase_q == PH_Q4);
      end else if (!ctrl_q.syncDis) begin
         inc = ctrl_q.run & syncInc_q;
      end else begin
         inc = ctrl_q.run & prescOut & ~prescPrev_q;
      end
   end

   // ************************************************************
   // Count pair, trigger clear and overflow
   // ************************************************************
   // Trigger only in clocked modes: async count is no compare base
   assign trig = (cmpMode_q == CMP_MODE_TRIG) & ~asyncMode
      & (count_q == cmpVal_q);

   always_comb begin
      count_d = count_q;
      if (trig) begin
         count_d = CNT_ZERO;
      end else if (inc) begin
         count_d = count_q + CNT_ONE;
      end
      if (cntLoWr) begin
         count_d[7:0] = wbReq.dat[7:0];
      end
      if (cntHiWr) begin
         count_d[15:8] = wbReq.dat[7:0];
      end
   end

   // Deliberately without reset; software must load it before use
   always_ff @(posedge clk) begin
      count_q <= count_d;
   end

   // The count has no reset, so its hold check waits for both bytes
   always_ff @(posedge clk) begin
      if (cntLoWr) begin
         cntKnown_q[0] <= 1'b1;
      end
      if (cntHiWr) begin
         cntKnown_q[1] <= 1'b1;
      end
   end

   assign ovfSet = inc & ~trig & ~cntWr & (count_q == CNT_MAX);

   // Set beats a clear in the same cycle
   always_ff @(posedge clk) begin
      if (rst || rstOther) begin
         ovf_q <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         wake_q <= ovfSet & sleepMode & asyncMode;
         if (ovfSet) begin
            ovf_q <= 1'b1;
         end else if (wrSel[IDX_STATUS] && wbReq.dat[STAT_OVF_BIT]) begin
            ovf_q <= 1'b0;
         end
      end
   end

   // Inverting amplifier ignores sleep so the crystal keeps swinging
   always_ff @(posedge clk) begin
      if (rst) begin
         oscOut_q <= 1'b0;
         oscOe_q <= 1'b0;
      end else begin
         oscOe_q <= ctrl_q.auxOsc;
         oscOut_q <= ctrl_q.auxOsc & ~pinLvl[PIN_OSC];
      end
   end

   assign wbDatO = rdat_q;
   assign wbAck = ack_q;
   assign oscOutPin = oscOut_q;
   assign oscOutOe = oscOe_q;
   assign overflowFlag = ovf_q;
   assign wakeUp = wake_q;

   // ************************************************************
   // Assertions
   // ************************************************************
   AST_TIMER_PHASE: assert property (@(posedge clk) disable iff (rst)
      (!ctrl_q.clkSel && inc) |-> (phase_q == PH_Q4) && !sleepMode)
      else $error("timer mode counted off the fourth phase");

   AST_SLEEP_HOLD: assert property (@(posedge clk) disable iff (rst)
      (sleepMode && ctrl_q.clkSel && !ctrl_q.syncDis && !cntWr && !trig
       && $past(sleepMode)) |=> $stable(count_q))
      else $error("synchronised count moved during sleep");

   AST_SYNC_DELAY: assert property (@(posedge clk) disable iff (rst)
      (ctrl_q.clkSel && !ctrl_q.syncDis && inc) |-> $past(sampleNow))
      else $error("synchronised count did not wait for sampling");

   AST_OVF_SET: assert property (@(posedge clk) disable iff (rst)
      (inc && !trig && !cntWr && count_q == CNT_MAX)
      |=> overflowFlag && count_q == CNT_ZERO)
      else $error("rollover did not set overflow flag");

   AST_TRIG_CLEAR: assert property (@(posedge clk)
      disable iff (rst || rstOther)
      (trig && !cntWr && !ovf_q) |=> count_q == CNT_ZERO && !ovf_q)
      else $error("trigger clear wrong or set the flag");

   AST_ASYNC_NOTRIG: assert property (@(posedge clk) disable iff (rst)
      asyncMode |-> !trig)
      else $error("trigger acted in asynchronous mode");

   AST_WRITE_WINS: assert property (@(posedge clk) disable iff (rst)
      (cntLoWr && trig) |=> count_q[7:0] == $past(wbReq.dat[7:0]))
      else $error("trigger beat a count write");

   AST_STOPPED: assert property (@(posedge clk) disable iff (rst)
      (&cntKnown_q && !ctrl_q.run && !cntWr && !trig)
      |=> $stable(count_q))
      else $error("count moved while stopped");

   AST_CTRL_RESET: assert property (@(posedge clk)
      rst |=> ctrl_q == CTRL_RESET)
      else $error("control not cleared by power-on reset");

   AST_WAKE: assert property (@(posedge clk) disable iff (rst)
      wakeUp |-> $past(asyncMode) && $past(sleepMode) && overflowFlag)
      else $error("wake pulse without async overflow in sleep");

   AST_ACK_PULSE: assert property (@(posedge clk) disable iff (rst)
      wbAck |=> !wbAck)
      else $error("ack held longer than one cycle");

   COV_TIMER_WRAP: cover property (@(posedge clk) disable iff (rst)
      !ctrl_q.clkSel && ovfSet);
   COV_SYNC_COUNT: cover property (@(posedge clk) disable iff (rst)
      ctrl_q.clkSel && !ctrl_q.syncDis && inc);
   COV_ASYNC_WAKE: cover property (@(posedge clk) disable iff (rst)
      wakeUp);
   COV_TRIGGER: cover property (@(posedge clk) disable iff (rst)
      trig && count_q != CNT_ZERO);
endmodule

// >>> test/sbtc_clk_src.sv
`timescale 1ns/1ps
module sbtc_clk_src (
   input wire logic clk, // Bench clock, paces the edges
   input wire logic ampOn, // Crystal amplifier enabled
   output logic extClk, // External clock pin
   output logic oscIn // Crystal input pin
);
   // ************************************************************
   // Edge source
   // ************************************************************
   initial begin
      extClk = 1'b0;
      oscIn = 1'b0;
   end

   // Both pins rest low between bursts; a crystal with no amplifier
   // behind it stays silent, so a dead enable shows as missing counts
   task automatic pulses(input int n, input int half, input bit onOsc);
      for (int i = 0; i < n; i++) begin
         if (onOsc && ampOn === 1'b1) oscIn <= 1'b1;
         if (!onOsc) extClk <= 1'b1;
         // Four clocks high and low keeps both phase samples safe
         repeat (half) @(posedge clk);
         oscIn <= 1'b0;
         extClk <= 1'b0;
         repeat (half) @(posedge clk);
      end
   endtask
endmodule

// >>> test/sbtc_top_tb.sv
`timescale 1ns/1ps
module sbtc_top_tb;
   import sbtc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rstOther = 1'b0;
   logic sleepMode = 1'b0;
   sbtc_wb_req_s wbReq = '0;
   logic [31:0] wbDatO;
   logic wbAck, extClkPin, oscInPin, oscOutPin, oscOutOe;
   logic overflowFlag, wakeUp;
   logic wakeSeen = 1'b0;
   logic [15:0] cnt;
   logic [31:0] rd;
   int n_fail = 0;
   int comparisons = 0;

   always #4 clk = ~clk;
   always @(posedge clk) if (wakeUp === 1'b1) wakeSeen <= 1'b1;

   sbtc_top sbtc_top_i (.clk(clk), .rst(rst), .rstOther(rstOther),
      .wbReq(wbReq), .wbDatO(wbDatO), .wbAck(wbAck),
      .sleepMode(sleepMode), .extClkPin(extClkPin),
      .oscInPin(oscInPin), .oscOutPin(oscOutPin),
      .oscOutOe(oscOutOe), .overflowFlag(overflowFlag),
      .wakeUp(wakeUp));
   sbtc_clk_src sbtc_clk_src_i (.clk(clk), .ampOn(oscOutOe),
      .extClk(extClkPin), .oscIn(oscInPin));

   // ************************************************************
   // Compare and report
   // ************************************************************
   task automatic chk(input string s, input logic [15:0] e, g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask

   task automatic chk1(input string s, input logic e, g);
      chk(s, {15'h0, e}, {15'h0, g});
   endtask

   task automatic chk_in(input string s, input logic [15:0] lo, hi, g);
      comparisons++;
      if ((g >= lo && g <= hi) !== 1'b1) begin
         n_fail++;
         $display("mismatch %s expected %h..%h seen %h", s, lo, hi, g);
      end
   endtask

   task automatic complete_run;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // ************************************************************
   // Bus and pin access
   // ************************************************************
   // Entered just after a rising edge; leaves one idle cycle behind
   task automatic wb(input logic [7:0] a, input logic we,
      input logic [7:0] d);
      int t;
      t = 0;
      wbReq <= '{1'b1, 1'b1, we, 4'hf, a, {24'h0, d}};
      do begin
         @(posedge clk);
         t++;
      end while (wbAck !== 1'b1 && t < 50);
      rd = wbDatO;
      if (t >= 50) begin
         n_fail++;
         $display("mismatch bus ack expected 1 seen 0");
      end
      wbReq <= '0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(a, 1'b1, d);
   endtask

   task automatic rr(input logic [7:0] a);
      wb(a, 1'b0, 8'h00);
   endtask

   task automatic wr16(input logic [15:0] v);
      wr(OFF_CNT_LO, v[7:0]);
      wr(OFF_CNT_HI, v[15:8]);
   endtask

   // High, low, high; low byte again if the high byte moved
   task automatic rd16;
      logic [7:0] h;
      rr(OFF_CNT_HI);
      h = rd[7:0];
      rr(OFF_CNT_LO);
      cnt[7:0] = rd[7:0];
      rr(OFF_CNT_HI);
      cnt[15:8] = rd[7:0];
      if (h !== cnt[15:8]) begin
         rr(OFF_CNT_LO);
         cnt[7:0] = rd[7:0];
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic pls(input int n, input bit onOsc);
      sbtc_clk_src_i.pulses(n, 4, onOsc);
      tick(12);
   endtask

   task automatic pulse(input bit por);
      if (por) rst <= 1'b1;
      else rstOther <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      rstOther <= 1'b0;
      @(posedge clk);
   endtask

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      complete_run();
   end

   initial begin
      tick(3);
      rst <= 1'b0;
      rr(OFF_CTRL);
      chk("ctrl after por", 16'h0, rd[15:0]);
      wr(OFF_CTRL, 8'h30);
      wr16(16'h1234);
      pulse(1'b0);
      rr(OFF_CTRL);
      chk("ctrl after other reset", 16'h30, rd[15:0]);
      pulse(1'b1);
      rr(OFF_CTRL);
      chk("ctrl after bor", 16'h0, rd[15:0]);
      rd16();
      chk("count kept over reset", 16'h1234, cnt);
      rr(8'h1c);
      chk("unmapped read", 16'h0, rd[15:0]);
      $display("test reset done");

      wr16(16'h0010);
      wr(OFF_CTRL, 8'h05);
      tick(40);
      wr(OFF_CTRL, 8'h04);
      rd16();
      chk_in("timer count", 16'h0019, 16'h001c, cnt);
      tick(20);
      rr(OFF_CNT_LO);
      chk("stopped count", {8'h00, cnt[7:0]}, rd[15:0]);
      sleepMode <= 1'b1;
      wr16(16'h0000);
      wr(OFF_CTRL, 8'h05);
      tick(40);
      wr(OFF_CTRL, 8'h04);
      rr(OFF_STATUS);
      chk1("sleep status", 1'b1, rd[STAT_SLEEP_BIT]);
      sleepMode <= 1'b0;
      rd16();
      chk("timer in sleep", 16'h0000, cnt);
      $display("test timer done");

      wr16(16'hfffe);
      wr(OFF_CTRL, 8'h05);
      tick(20);
      wr(OFF_CTRL, 8'h04);
      chk1("overflow flag", 1'b1, overflowFlag);
      rr(OFF_STATUS);
      chk1("overflow status", 1'b1, rd[STAT_OVF_BIT]);
      rd16();
      chk_in("wrapped count", 16'h0002, 16'h0005, cnt);
      wr(OFF_STATUS, 8'h01);
      chk1("flag cleared", 1'b0, overflowFlag);
      $display("test overflow done");

      for (int ps = 0; ps < 4; ps++) begin
         wr16(16'h0000);
         wr(OFF_CTRL, {2'h0, ps[1:0], 4'h3});
         pls(16, 1'b0);
         wr(OFF_CTRL, 8'h02);
         rd16();
         chk("sync count", 16'h10 >> ps, cnt);
      end
      // Five edges in sleep leave the divide-by-4 output low
      wr16(16'h0000);
      wr(OFF_CTRL, 8'h23);
      sleepMode <= 1'b1;
      pls(5, 1'b0);
      rd16();
      chk("sync count in sleep", 16'h0000, cnt);
      sleepMode <= 1'b0;
      pls(1, 1'b0);
      rd16();
      chk("prescaler ran in sleep", 16'h0001, cnt);
      wr(OFF_CTRL, 8'h32);
      wr16(16'h0000);
      wr(OFF_CTRL, 8'h33);
      pls(3, 1'b0);
      wr(OFF_CTRL, 8'h32);
      wr(OFF_CNT_LO, 8'h00);
      wr(OFF_CTRL, 8'h33);
      pls(3, 1'b0);
      wr(OFF_CTRL, 8'h32);
      rd16();
      chk("prescaler cleared", 16'h0000, cnt);
      $display("test sync counter done");

      wr16(16'h0000);
      wr(OFF_CTRL, 8'h0a);
      tick(64);
      chk1("amp enable", 1'b1, oscOutOe);
      chk1("amp output", 1'b1, oscOutPin);
      wr(OFF_CTRL, 8'h0b);
      pls(8, 1'b1);
      pls(4, 1'b0);
      wr(OFF_CTRL, 8'h0a);
      rd16();
      chk("osc pin count", 16'h0008, cnt);
      $display("test oscillator done");

      wr(OFF_CMP_LO, 8'hfe);
      wr(OFF_CMP_HI, 8'hff);
      wr(OFF_CMP_MODE, 8'h0b);
      wr16(16'hfffc);
      wakeSeen <= 1'b0;
      sleepMode <= 1'b1;
      wr(OFF_CTRL, 8'h07);
      pls(8, 1'b0);
      wr(OFF_CTRL, 8'h06);
      sleepMode <= 1'b0;
      rd16();
      chk("async count", 16'h0004, cnt);
      chk1("async overflow", 1'b1, overflowFlag);
      chk1("wake pulse", 1'b1, wakeSeen);
      $display("test async done");

      wr(OFF_STATUS, 8'h01);
      wr(OFF_CMP_LO, 8'h05);
      wr(OFF_CMP_HI, 8'h00);
      wr16(16'h0000);
      wr(OFF_CTRL, 8'h05);
      tick(100);
      wr(OFF_CTRL, 8'h04);
      rd16();
      chk_in("period count", 16'h0000, 16'h0005, cnt);
      chk1("no flag on trigger", 1'b0, overflowFlag);
      wr(OFF_CMP_LO, 8'h03);
      wr16(16'h0000);
      wr(OFF_CTRL, 8'h03);
      pls(5, 1'b0);
      wr(OFF_CTRL, 8'h02);
      rd16();
      chk("sync trigger count", 16'h0002, cnt);
      // Compare at zero keeps the trigger firing while the low byte lands
      wr(OFF_CMP_LO, 8'h00);
      wr16(16'h0000);
      wr(OFF_CNT_LO, 8'h07);
      rd16();
      chk("write beats trigger", 16'h0007, cnt);
      $display("test trigger done");
      complete_run();
   end
endmodule
